//--- bench/ccu_compare_unit_bench.sv
// Self-checking bench for the compare condition unit
`default_nettype none
module ccu_compare_unit_bench
	import ccu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rung_cond;
	logic        skip_rung;
	logic        error_flag;
	logic [5:0]  arith_flags;
	int          err_count = 0;
	int          samples_checked = 0;
	logic [15:0] dat [2][4] = '{'{16'h8000, 16'h0, 16'h1, 16'hffff}, '{16'h5, 16'h0, 16'h5, 16'h1}};
	int          cmpv [2][4] = '{'{1, -1, -1, 1}, '{0, -1, 0, -1}};
	logic        cur;
	logic [31:0] q;
	logic        e;

	ccu_compare_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rung_cond(rung_cond), .skip_rung(skip_rung),
		.error_flag(error_flag), .arith_flags(arith_flags));
	ccu_seq_model seq (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		seq.xfer(1'b1, a, d, q, e);
	endtask : wr

	// Execute, then look once the result edge has landed
	task automatic run(input logic [9:0] op, input logic [1:0] form);
		wr(ADDR_OP, {1'b1, 13'h0, form, 6'h0, op});
		@(posedge pclk);
		@(negedge pclk);
	endtask : run

	task automatic ld(input logic [15:0] a0, a1, b0, b1);
		wr(ADDR_A_LO, {16'h0, a0});
		wr(ADDR_A_HI, {16'h0, a1});
		wr(ADDR_B_LO, {16'h0, b0});
		wr(ADDR_B_HI, {16'h0, b1});
	endtask : ld

	function automatic logic rel(input int g, input int c);
		case (g)
			0: return c == 0;
			1: return c != 0;
			2: return c < 0;
			3: return c <= 0;
			4: return c > 0;
			default: return c >= 0;
		endcase
	endfunction : rel

	initial begin
		#200000;
		err_count++;
		$display("Error watchdog expired");
		wrap_up();
	end

	initial begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		seq.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
		check("status_reset", 32'h0, q);
		$display("test reset done");
		cur = 1'b0;
		for (int d = 0; d < 3; d++) begin
			ld(dat[d % 2][0], dat[d % 2][1], dat[d % 2][2], dat[d % 2][3]);
			for (int g = 0; g < 6; g++) begin
				for (int v = 0; v < OP_VARIANTS; v++) begin
					int f;
					logic r;
					f = (g * 4 + v + d) % 3;
					r = rel(g, cmpv[d % 2][v]);
					cur = (f == 0) ? r : (f == 1) ? (cur & r) : (cur | r);
					run(OP_EQ + 10'(g * OP_GROUP_STEP + v), 2'(f));
					check("rung_cond", {31'h0, cur}, {31'h0, rung_cond});
					check("skip_rung", {31'h0, f == 1 && !cur}, {31'h0, skip_rung});
				end
			end
		end
		$display("test input compares done");
		// Time blocks go in whole, three words each
		ld(16'h1530, 16'h0510, 16'h1510, 16'h0510);
		wr(ADDR_TA2, 32'h9806);
		wr(ADDR_TB2, 32'h0006);
		wr(ADDR_CTRL, 32'h0);
		run(OP_TIME_LT, FORM_LOAD);
		check("rung_cond", 32'h1, {31'h0, rung_cond});
		check("flags", 32'h1c, {26'h0, arith_flags});
		wr(ADDR_CTRL, 32'h20);
		for (int g = 0; g < 6; g++) begin
			run(OP_TIME_EQ + 10'(g), FORM_LOAD);
			check("rung_cond", {31'h0, rel(g, 1)}, {31'h0, rung_cond});
			check("flags", 32'h13, {26'h0, arith_flags});
		end
		wr(ADDR_CTRL, 32'h3f);
		run(OP_TIME_EQ, FORM_OR);
		check("rung_cond", 32'h0, {31'h0, rung_cond});
		check("error_flag", 32'h1, {31'h0, error_flag});
		seq.xfer(1'b0, ADDR_STATUS, 32'h0, q, e);
		check("status", 32'h14e, q);
		wr(ADDR_CTRL, 32'h39);
		seq.xfer(1'b0, ADDR_CTRL, 32'h0, q, e);
		check("ctrl_readback", 32'h39, q);
		run(OP_TIME_EQ, FORM_LOAD);
		check("rung_cond", 32'h1, {31'h0, rung_cond});
		check("error_flag", 32'h0, {31'h0, error_flag});
		check("flags", 32'h25, {26'h0, arith_flags});
		$display("test time compares done");
		run(10'd304, FORM_LOAD);
		run(OP_NE, 2'd3);
		check("rung_cond", 32'h1, {31'h0, rung_cond});
		seq.xfer(1'b0, 32'h40, 32'h0, q, e);
		check("unmapped_err", 32'h1, {31'h0, e});
		check("unmapped_data", 32'h0, q);
		$display("test refusals done");
		wrap_up();
	end
endmodule : ccu_compare_unit_bench
`default_nettype wire

//--- bench/ccu_compare_unit_props.sv
// Port-level assertions for the compare condition unit
`default_nettype none
module ccu_compare_unit_props
	import ccu_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rung_cond,
	input wire logic        skip_rung,
	input wire logic        error_flag,
	input wire logic [5:0]  arith_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic exec_w = psel & penable & pready & pwrite & (paddr == ADDR_OP) & pwdata[31]
		& pstrb[3];
	wire logic any_f = |arith_flags;

	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_SLVERR_MAP: assert property (pready && paddr[1:0] == 2'b00
		|-> pslverr == (paddr > ADDR_STATUS))
		else $error("pslverr wrong for address");
	AST_UNMAPPED_READ: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	AST_COND_CAUSE: assert property ($changed(rung_cond) |-> $past(exec_w))
		else $error("rung_cond changed without execute");
	AST_ERR_CAUSE: assert property ($changed(error_flag) |-> $past(exec_w))
		else $error("error_flag changed without execute");
	AST_ERR_OFF: assert property (error_flag |-> !rung_cond)
		else $error("condition on with error flag");
	AST_SKIP_OFF: assert property (skip_rung |-> !rung_cond)
		else $error("skip with condition on");
	AST_EQ_NE: assert property (any_f |-> arith_flags[5] != arith_flags[4])
		else $error("eq and ne flags not opposite");
	AST_LE_GE: assert property (any_f |->
		arith_flags[2] == (arith_flags[5] | arith_flags[3])
		&& arith_flags[0] == (arith_flags[5] | arith_flags[1]))
		else $error("le or ge flag inconsistent");
	AST_LT_GT: assert property (any_f |->
		(arith_flags[3] + arith_flags[1] + arith_flags[5]) == 2'd1)
		else $error("relation flags not one hot");
	AST_FLAGS_CAUSE: assert property ($changed(arith_flags) |-> $past(exec_w))
		else $error("flags changed without execute");

	cover property ($rose(skip_rung));
	cover property ($rose(error_flag));
	cover property (pready && pslverr);
endmodule : ccu_compare_unit_props

bind ccu_compare_unit ccu_compare_unit_props u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rung_cond(rung_cond), .skip_rung(skip_rung), .error_flag(error_flag),
	.arith_flags(arith_flags));
`default_nettype wire

//--- bench/ccu_seq_model.sv
// Sequencer model issuing APB transfers to the compare unit
`default_nettype none
module ccu_seq_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [31:0] paddr,
	output var  logic [31:0] pwdata,
	output var  logic [3:0]  pstrb
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
	end
	// Whole transfer: setup, access until pready, then release
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : ccu_seq_model
`default_nettype wire

//--- hw/ccu_compare_unit.sv
// Compare condition unit: input and time comparisons driving rung condition
`default_nettype none
module ccu_compare_unit
	import ccu_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             rung_cond,
	output logic             skip_rung,
	output logic             error_flag,
	output logic [5:0]       arith_flags
);
	// ==========================================================
	// Register storage
	// ==========================================================
	logic [31:0]    op_reg;
	logic [31:0]    a_lo_reg;
	logic [31:0]    a_hi_reg;
	logic [31:0]    b_lo_reg;
	logic [31:0]    b_hi_reg;
	logic [31:0]    ctrl_reg;
	logic [31:0]    ta2_reg;
	logic [31:0]    tb2_reg;
	ccu_result_type res_reg;
	ccu_result_type res_next;
	logic           skip_reg;
	logic           skip_next;
	logic [31:0]    prdata_reg;
	logic [31:0]    prdata_next;
	logic           pready_reg;
	logic           pslverr_reg;

	// ==========================================================
	// APB decode
	// ==========================================================
	logic setup_ph;
	logic wr_go;
	logic sel_op;
	logic sel_a_lo;
	logic sel_a_hi;
	logic sel_b_lo;
	logic sel_b_hi;
	logic sel_ctrl;
	logic sel_ta2;
	logic sel_tb2;
	logic sel_status;
	logic mapped;

	// No wait state: answer in the cycle after setup
	assign setup_ph   = psel & ~penable;
	assign wr_go      = psel & penable & pwrite & pready_reg;
	assign sel_op     = paddr == ADDR_OP;
	assign sel_a_lo   = paddr == ADDR_A_LO;
	assign sel_a_hi   = paddr == ADDR_A_HI;
	assign sel_b_lo   = paddr == ADDR_B_LO;
	assign sel_b_hi   = paddr == ADDR_B_HI;
	assign sel_ctrl   = paddr == ADDR_CTRL;
	assign sel_ta2    = paddr == ADDR_TA2;
	assign sel_tb2    = paddr == ADDR_TB2;
	assign sel_status = paddr == ADDR_STATUS;
	assign mapped     = sel_op | sel_a_lo | sel_a_hi | sel_b_lo | sel_b_hi | sel_ctrl |
		sel_ta2 | sel_tb2 | sel_status;

	function automatic logic [31:0] strb_merge(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				r[k*8 +: 8] = data[k*8 +: 8];
			end
		end
		return r;
	endfunction : strb_merge

	// ==========================================================
	// Operation decode
	// ==========================================================
	logic [31:0]  op_word;
	logic [9:0]   opcode;
	ccu_form_type form;
	logic         fire;
	logic         in_range;
	logic         is_time;
	logic [9:0]   rel_off;
	logic [2:0]   rel_idx;
	logic [1:0]   variant;
	logic         opt_dbl;
	logic         opt_sgn;
	logic         valid_op;

	// Execute decodes the word on the bus, which lands in op_reg only at this edge
	assign op_word  = (wr_go & sel_op) ? strb_merge(op_reg, pwdata, pstrb) : op_reg;
	assign opcode   = op_word[9:0];
	assign form     = ccu_form_type'(op_word[17:16]);
	// Writing the operation register with bit 31 set and pstrb[3] high executes it
	assign fire     = wr_go & sel_op & pstrb[3] & pwdata[31];
	assign in_range = (opcode >= OP_EQ) && (opcode <= OP_GE + 10'(OP_VARIANTS - 1));
	assign is_time  = (opcode >= OP_TIME_LO) && (opcode <= OP_TIME_HI);
	assign rel_off  = opcode - OP_EQ;
	assign rel_idx  = 3'(rel_off / 10'(OP_GROUP_STEP));
	assign variant  = 2'(rel_off % 10'(OP_GROUP_STEP));
	assign opt_dbl  = variant[0] | (variant == 2'd3);
	assign opt_sgn  = variant[1];
	assign valid_op = (is_time | (in_range && (rel_off % 10'(OP_GROUP_STEP)) <
		10'(OP_VARIANTS))) && (form != 2'd3);

	// ==========================================================
	// Numeric comparison
	// ==========================================================
	logic [31:0] a_val;
	logic [31:0] b_val;
	logic        num_lt;
	logic        num_eq;

	// Upper half from the higher-address word only when double length
	assign a_val  = opt_dbl ? {a_hi_reg[15:0], a_lo_reg[15:0]} :
		{{16{opt_sgn & a_lo_reg[15]}}, a_lo_reg[15:0]};
	assign b_val  = opt_dbl ? {b_hi_reg[15:0], b_lo_reg[15:0]} :
		{{16{opt_sgn & b_lo_reg[15]}}, b_lo_reg[15:0]};
	assign num_eq = a_val == b_val;
	// BCD orders like unsigned binary, so unsigned covers both
	assign num_lt = opt_sgn ? ($signed(a_val) < $signed(b_val)) : (a_val < b_val);

	// ==========================================================
	// Time comparison
	// ==========================================================
	logic t_all_masked;
	logic t_lt;
	logic t_gt;

	ccu_time_cmp u_time (
		.first_w0   (a_lo_reg[15:0]),
		.first_w1   (a_hi_reg[15:0]),
		.first_w2   (ta2_reg[15:0]),
		.second_w0  (b_lo_reg[15:0]),
		.second_w1  (b_hi_reg[15:0]),
		.second_w2  (tb2_reg[15:0]),
		.mask_word  (ctrl_reg[15:0]),
		.all_masked (t_all_masked),
		.is_less    (t_lt),
		.is_greater (t_gt)
	);

	// ==========================================================
	// Relation and condition
	// ==========================================================
	logic          r_lt;
	logic          r_eq;
	logic          r_gt;
	logic [2:0]    rel_sel;
	logic          rel_true;
	ccu_flags_type t_flags;

	assign r_lt    = is_time ? t_lt : num_lt;
	assign r_gt    = is_time ? t_gt : (~num_lt & ~num_eq);
	assign r_eq    = ~r_lt & ~r_gt;
	assign rel_sel = is_time ? 3'(opcode - OP_TIME_EQ) : rel_idx;
	always_comb begin
		unique case (rel_sel)
			3'd0:    rel_true = r_eq;
			3'd1:    rel_true = ~r_eq;
			3'd2:    rel_true = r_lt;
			3'd3:    rel_true = r_lt | r_eq;
			3'd4:    rel_true = r_gt;
			3'd5:    rel_true = r_gt | r_eq;
			default: rel_true = 1'b0;
		endcase
	end
	assign t_flags = '{eq: r_eq, ne: ~r_eq, lt: r_lt, le: r_lt | r_eq,
		gt: r_gt, ge: r_gt | r_eq};

	always_comb begin
		res_next  = res_reg;
		skip_next = skip_reg;
		if (fire && valid_op) begin
			if (is_time && t_all_masked) begin
				res_next.cond       = 1'b0;
				res_next.error_flag = 1'b1;
				skip_next           = form == FORM_AND;
			end else begin
				res_next.error_flag = 1'b0;
				unique case (form)
					FORM_LOAD: res_next.cond = rel_true;
					FORM_AND:  res_next.cond = res_reg.cond & rel_true;
					FORM_OR:   res_next.cond = res_reg.cond | rel_true;
					default:   res_next.cond = res_reg.cond;
				endcase
				skip_next = (form == FORM_AND) & ~(res_reg.cond & rel_true);
				if (is_time) begin
					res_next.flags       = t_flags;
					res_next.flags_valid = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Read mux
	// ==========================================================
	logic [31:0] status_word;

	assign status_word = {23'h0, res_reg.flags_valid, res_reg.flags,
		res_reg.error_flag, res_reg.cond};

	always_comb begin
		prdata_next = prdata_reg;
		if (setup_ph && !pwrite) begin
			unique case (1'b1)
				sel_op:     prdata_next = {14'h0, op_reg[17:16], 6'h0, op_reg[9:0]};
				sel_a_lo:   prdata_next = a_lo_reg;
				sel_a_hi:   prdata_next = a_hi_reg;
				sel_b_lo:   prdata_next = b_lo_reg;
				sel_b_hi:   prdata_next = b_hi_reg;
				sel_ctrl:   prdata_next = ctrl_reg;
				sel_ta2:    prdata_next = ta2_reg;
				sel_tb2:    prdata_next = tb2_reg;
				sel_status: prdata_next = status_word;
				default:    prdata_next = 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Sequential
	// ==========================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0;
		end else begin
			pready_reg  <= setup_ph;
			pslverr_reg <= setup_ph & ~mapped;
			prdata_reg  <= prdata_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_reg   <= 32'h0;
			a_lo_reg <= 32'h0;
			a_hi_reg <= 32'h0;
			b_lo_reg <= 32'h0;
			b_hi_reg <= 32'h0;
			ctrl_reg <= 32'h0;
			ta2_reg  <= 32'h0;
			tb2_reg  <= 32'h0;
		end else if (wr_go) begin
			if (sel_op)   op_reg   <= strb_merge(op_reg, pwdata, pstrb);
			if (sel_a_lo) a_lo_reg <= strb_merge(a_lo_reg, pwdata, pstrb);
			if (sel_a_hi) a_hi_reg <= strb_merge(a_hi_reg, pwdata, pstrb);
			if (sel_b_lo) b_lo_reg <= strb_merge(b_lo_reg, pwdata, pstrb);
			if (sel_b_hi) b_hi_reg <= strb_merge(b_hi_reg, pwdata, pstrb);
			if (sel_ctrl) ctrl_reg <= strb_merge(ctrl_reg, pwdata, pstrb);
			if (sel_ta2)  ta2_reg  <= strb_merge(ta2_reg, pwdata, pstrb);
			if (sel_tb2)  tb2_reg  <= strb_merge(tb2_reg, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_reg  <= '0;
			skip_reg <= 1'b0;
		end else begin
			res_reg  <= res_next;
			skip_reg <= skip_next;
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign rung_cond   = res_reg.cond;
	assign skip_rung   = skip_reg;
	assign error_flag  = res_reg.error_flag;
	assign arith_flags = res_reg.flags;
endmodule : ccu_compare_unit
`default_nettype wire

//--- hw/ccu_pkg.sv
// Package for the compare condition unit: opcodes, fields, register map
`default_nettype none
package ccu_pkg;
	localparam logic [9:0] OP_EQ      = 10'd300;
	localparam logic [9:0] OP_NE      = 10'd305;
	localparam logic [9:0] OP_LT      = 10'd310;
	localparam logic [9:0] OP_LE      = 10'd315;
	localparam logic [9:0] OP_GT      = 10'd320;
	localparam logic [9:0] OP_GE      = 10'd325;
	localparam logic [9:0] OP_TIME_LO = 10'd341;
	localparam logic [9:0] OP_TIME_HI = 10'd346;
	localparam logic [9:0] OP_TIME_EQ = 10'd341;
	localparam logic [9:0] OP_TIME_NE = 10'd342;
	localparam logic [9:0] OP_TIME_LT = 10'd343;
	localparam logic [9:0] OP_TIME_LE = 10'd344;
	localparam logic [9:0] OP_TIME_GT = 10'd345;
	localparam logic [9:0] OP_TIME_GE = 10'd346;
	localparam int OP_VARIANTS      = 4;
	localparam int OP_GROUP_STEP    = 5;
	localparam int TIME_MASK_BITS   = 6;
	localparam int TIME_WORDS       = 3;
	localparam int YEAR_WRAP        = 8'h98;
	localparam logic [31:0] ADDR_OP      = 32'h0000_0000;
	localparam logic [31:0] ADDR_A_LO    = 32'h0000_0004;
	localparam logic [31:0] ADDR_A_HI    = 32'h0000_0008;
	localparam logic [31:0] ADDR_B_LO    = 32'h0000_000c;
	localparam logic [31:0] ADDR_B_HI    = 32'h0000_0010;
	localparam logic [31:0] ADDR_CTRL    = 32'h0000_0014;
	localparam logic [31:0] ADDR_TA2     = 32'h0000_0018;
	localparam logic [31:0] ADDR_TB2     = 32'h0000_001c;
	localparam logic [31:0] ADDR_STATUS  = 32'h0000_0020;
	localparam int ST_COND  = 0;
	localparam int ST_ERR   = 1;
	localparam int ST_FLAGS = 2;
	localparam int ST_VALID = 8;

	typedef enum logic [1:0] {
		FORM_LOAD,
		FORM_AND,
		FORM_OR
	} ccu_form_type;

	typedef struct packed {
		logic eq;
		logic ne;
		logic lt;
		logic le;
		logic gt;
		logic ge;
	} ccu_flags_type;

	typedef struct packed {
		logic          cond;
		logic          error_flag;
		ccu_flags_type flags;
		logic          flags_valid;
	} ccu_result_type;
endpackage : ccu_pkg
`default_nettype wire

//--- hw/ccu_time_cmp.sv
// Masked BCD calendar comparison of two three-word time blocks
`default_nettype none
module ccu_time_cmp
	import ccu_pkg::*;
(
	input  wire logic [15:0] first_w0,
	input  wire logic [15:0] first_w1,
	input  wire logic [15:0] first_w2,
	input  wire logic [15:0] second_w0,
	input  wire logic [15:0] second_w1,
	input  wire logic [15:0] second_w2,
	input  wire logic [15:0] mask_word,
	output logic             all_masked,
	output logic             is_less,
	output logic             is_greater
);
	logic [7:0] fa [TIME_MASK_BITS];
	logic [7:0] fb [TIME_MASK_BITS];
	logic [8:0] ka [TIME_MASK_BITS];
	logic [8:0] kb [TIME_MASK_BITS];
	logic [TIME_MASK_BITS:0] lt_chain;
	logic [TIME_MASK_BITS:0] gt_chain;

	// Fields 0..5: sec, min, hour, day, month, year
	assign fa[0] = first_w0[7:0];
	assign fa[1] = first_w0[15:8];
	assign fa[2] = first_w1[7:0];
	assign fa[3] = first_w1[15:8];
	assign fa[4] = first_w2[7:0];
	assign fa[5] = first_w2[15:8];
	assign fb[0] = second_w0[7:0];
	assign fb[1] = second_w0[15:8];
	assign fb[2] = second_w1[7:0];
	assign fb[3] = second_w1[15:8];
	assign fb[4] = second_w2[7:0];
	assign fb[5] = second_w2[15:8];

	assign all_masked = &mask_word[TIME_MASK_BITS-1:0];
	assign lt_chain[TIME_MASK_BITS] = 1'b0;
	assign gt_chain[TIME_MASK_BITS] = 1'b0;

	genvar i;
	generate
		for (i = 0; i < TIME_MASK_BITS; i++) begin : g_field
			if (i == TIME_MASK_BITS - 1) begin : g_year
				// 98/99 precede 00 in century order
				assign ka[i] = {fa[i] < 8'(YEAR_WRAP), fa[i]};
				assign kb[i] = {fb[i] < 8'(YEAR_WRAP), fb[i]};
			end else begin : g_plain
				assign ka[i] = {1'b0, fa[i]};
				assign kb[i] = {1'b0, fb[i]};
			end
			// Most significant unmasked differing field decides
			assign lt_chain[i] = lt_chain[i+1] | (~gt_chain[i+1] & ~mask_word[i] &
				(ka[i] < kb[i]));
			assign gt_chain[i] = gt_chain[i+1] | (~lt_chain[i+1] & ~mask_word[i] &
				(ka[i] > kb[i]));
		end
	endgenerate

	assign is_less    = lt_chain[0];
	assign is_greater = gt_chain[0];
endmodule : ccu_time_cmp
`default_nettype wire
